// ### hw/lmfc_sysref_latency_align.sv
`timescale 1ns/100ps
`default_nettype none
module lmfc_sysref_latency_align (
   input  wire logic                        CLK_SYS,
   input  wire logic                        RST,
   input  wire logic [11:0]                 AVS_ADDRESS,
   input  wire logic                        AVS_READ,
   input  wire logic                        AVS_WRITE,
   input  wire logic [31:0]                 AVS_WRITEDATA,
   output logic [31:0]                      AVS_READDATA,
   output logic                             AVS_WAITREQUEST,
   input  wire logic                        SYSREF_RISE,
   input  wire logic                        SYSREF_FALL,
   output lmfc_align_pkg::lmfc_out_s        LMFC_OUT,
   output logic                             SUBCLASS1_ACTIVE,
   output logic                             TIMESTAMP_MODE
);
   import lmfc_align_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACK  = 2'b01
   } bus_state_e;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Offset in frames, rounded down to valid step for F
   function automatic logic [4:0] offset_frames(input logic [4:0] ofs,
                                                input logic [3:0] fm1);
      if (fm1 == 4'h0)
         return {ofs[4:2], 2'b00};
      else if (fm1 == 4'h1)
         return {ofs[4:1], 1'b0};
      else
         return ofs;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   bus_state_e  bus_reg, bus_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [7:0]  ctrl_reg, ctrl_next;
   logic [7:0]  sync_reg, sync_next;
   logic [7:0]  pll_reg, pll_next;
   logic [7:0]  ofs_reg, ofs_next;
   logic [7:0]  sub_reg, sub_next;
   logic [3:0]  fm1_reg, fm1_next;
   logic [4:0]  km1_reg, km1_next;
   logic [4:0]  ofs_act_reg, ofs_act_next;
   logic [3:0]  oct_reg, oct_next;
   logic [4:0]  frm_reg, frm_next;
   logic [2:0]  div_reg, div_next;
   logic [4:0]  dly_reg, dly_next;
   logic        dly_run_reg, dly_run_next;
   logic        lmfc_reg, lmfc_next;
   logic        ftick_reg, ftick_next;
   logic        dres_reg, dres_next;

   logic        sr_event;
   logic [7:0]  mon;
   logic        armed;
   logic        realign;
   logic        wr_hit;
   bus_req_s    req;

   assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                  writedata: AVS_WRITEDATA};

   sysref_capture u_cap (
      .clk         (CLK_SYS),
      .rst         (RST),
      .sysref_rise (SYSREF_RISE),
      .sysref_fall (SYSREF_FALL),
      .trans_sel   (ctrl_reg[SYSREF_TRANS_BIT]),
      .edge_sel    (ctrl_reg[SYSREF_EDGE_BIT]),
      .event_pulse (sr_event),
      .monitor     (mon)
   );

   // ------------------------------------------------------------
   // Register bus and controls
   // ------------------------------------------------------------
   always_comb begin
      armed   = ctrl_reg[SYSREF_MODE_LSB +: 2] != MODE_OFF;
      // Subclass 0 never realigns, so SYSREF may float
      realign = sr_event && armed && (sub_reg[SUBCLASS_LSB +: 3] != 3'h0)
                && !sync_reg[0];
      // Write lands at the edge that ends the transfer
      wr_hit  = (bus_reg == ST_ACK) && req.write;
      bus_next     = bus_reg;
      rdata_next   = rdata_reg;
      ctrl_next    = ctrl_reg;
      sync_next    = sync_reg;
      pll_next     = pll_reg;
      ofs_next     = ofs_reg;
      sub_next     = sub_reg;
      fm1_next     = fm1_reg;
      km1_next     = km1_reg;
      unique case (bus_reg)
         ST_IDLE: begin
            if (req.read || req.write) begin
               bus_next = ST_ACK;
            end
            if (req.read) begin
               unique case (req.address)
                  OFS_SYSREF_CTRL: rdata_next = {24'h0, ctrl_reg};
                  OFS_SYSREF_MON:  rdata_next = {24'h0, mon};
                  OFS_CHIP_SYNC:   rdata_next = {24'h0, sync_reg};
                  OFS_SERDES_PLL:  rdata_next = {24'h0, pll_reg};
                  OFS_MULTIFRAME_CLOCK_OFFSET: rdata_next = {24'h0, ofs_reg};
                  OFS_SUBCLASS:    rdata_next = {24'h0, sub_reg};
                  OFS_LINK_PARAM:  rdata_next = {16'h0, 3'h0, km1_reg, 4'h0, fm1_reg};
                  default:         rdata_next = 32'h0;
               endcase
            end
         end
         ST_ACK: begin
            bus_next = ST_IDLE;
            if (wr_hit) begin
               unique case (req.address)
                  OFS_SYSREF_CTRL: ctrl_next = req.writedata[7:0];
                  OFS_CHIP_SYNC:   sync_next = {7'h0, req.writedata[0]};
                  OFS_SERDES_PLL:  pll_next  = req.writedata[7:0];
                  OFS_MULTIFRAME_CLOCK_OFFSET: ofs_next  = {3'h0, req.writedata[4:0]};
                  OFS_SUBCLASS:    sub_next  = {req.writedata[7:5], 5'h0};
                  OFS_LINK_PARAM: begin
                     fm1_next = req.writedata[3:0];
                     km1_next = req.writedata[12:8];
                  end
                  default: ;
               endcase
            end
         end
         default: bus_next = ST_IDLE;
      endcase
      // N-shot self-clear after the qualifying event; write loses to it
      if (sr_event && ctrl_reg[SYSREF_MODE_LSB +: 2] == MODE_NSHOT) begin
         ctrl_next[SYSREF_MODE_LSB +: 2] = MODE_OFF;
      end
   end

   // ------------------------------------------------------------
   // Octet, frame and multiframe counters
   // ------------------------------------------------------------
   always_comb begin
      oct_next     = oct_reg;
      frm_next     = frm_reg;
      div_next     = div_reg + 3'h1;
      ofs_act_next = ofs_act_reg;
      dly_next     = dly_reg;
      dly_run_next = dly_run_reg;
      lmfc_next    = 1'b0;
      ftick_next   = 1'b0;
      dres_next    = 1'b0;
      if (realign) begin
         // Offset latched only here, delays the restart
         ofs_act_next = offset_frames(ofs_reg[4:0], fm1_reg);
         dly_next     = offset_frames(ofs_reg[4:0], fm1_reg);
         dly_run_next = 1'b1;
         oct_next     = 4'h0;
         frm_next     = 5'h0;
         div_next     = 3'h0;
         dres_next    = 1'b1;
      end else begin
         if (oct_reg == fm1_reg) begin
            oct_next   = 4'h0;
            ftick_next = 1'b1;
            if (dly_run_reg) begin
               if (dly_reg == 5'h0) begin
                  dly_run_next = 1'b0;
                  frm_next     = 5'h0;
                  lmfc_next    = 1'b1;
               end else begin
                  dly_next = dly_reg - 5'h1;
               end
            end else if (frm_reg == km1_reg) begin
               frm_next  = 5'h0;
               lmfc_next = 1'b1;
            end else begin
               frm_next = frm_reg + 5'h1;
            end
         end else begin
            oct_next = oct_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         bus_reg     <= ST_IDLE;
         rdata_reg   <= 32'h0;
         ctrl_reg    <= RST_SYSREF_CTRL;
         sync_reg    <= RST_CHIP_SYNC;
         pll_reg     <= RST_SERDES_PLL;
         ofs_reg     <= RST_MULTIFRAME_CLOCK_OFFSET;
         sub_reg     <= RST_SUBCLASS;
         fm1_reg     <= RST_F_MINUS1[3:0];
         km1_reg     <= RST_K_MINUS1[4:0];
         ofs_act_reg <= 5'h0;
         oct_reg     <= 4'h0;
         frm_reg     <= 5'h0;
         div_reg     <= 3'h0;
         dly_reg     <= 5'h0;
         dly_run_reg <= 1'b0;
         lmfc_reg    <= 1'b0;
         ftick_reg   <= 1'b0;
         dres_reg    <= 1'b0;
      end else begin
         bus_reg     <= bus_next;
         rdata_reg   <= rdata_next;
         ctrl_reg    <= ctrl_next;
         sync_reg    <= sync_next;
         pll_reg     <= pll_next;
         ofs_reg     <= ofs_next;
         sub_reg     <= sub_next;
         fm1_reg     <= fm1_next;
         km1_reg     <= km1_next;
         ofs_act_reg <= ofs_act_next;
         oct_reg     <= oct_next;
         frm_reg     <= frm_next;
         div_reg     <= div_next;
         dly_reg     <= dly_next;
         dly_run_reg <= dly_run_next;
         lmfc_reg    <= lmfc_next;
         ftick_reg   <= ftick_next;
         dres_reg    <= dres_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign AVS_WAITREQUEST  = (bus_reg == ST_IDLE);
   assign AVS_READDATA     = rdata_reg;
   assign LMFC_OUT         = '{lmfc_tick: lmfc_reg, frame_tick: ftick_reg,
                               div_reset: dres_reg, div_phase: div_reg};
   assign SUBCLASS1_ACTIVE = (sub_reg[SUBCLASS_LSB +: 3] != 3'h0);
   assign TIMESTAMP_MODE   = sync_reg[0];
endmodule // lmfc_sysref_latency_align
`default_nettype wire

// ### hw/lmfc_align_pkg.sv
// Operation
// - Two-DDC example decimates the stream by eight
// - Link carries M4 N14 Np16 CS0 K32
// - Subclass field bits 7:5, reset Subclass 1
// - Subclass 0 works with SYSREF unconnected
// - LMFC ticks at every multiframe start
// - Subclass 1 SYSREF realigns LMFC and dividers
// - Five-bit Multiframe_clock_offset delays in frame steps
// - Offset step depends on octets per frame
// - Readable Sysref_timing_monitor register
// - Transition select picks rising or falling transition
// - Edge select picks clock edge for sampling
// - Chip sync mode bit, zero is normal
// - SYSREF mode arms; N-shot self-clears on event
// - LMFC period is S times K samples
package lmfc_align_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_SYSREF_CTRL   = 12'h120;
   localparam logic [11:0] OFS_SYSREF_MON    = 12'h128;
   localparam logic [11:0] OFS_CHIP_SYNC     = 12'h1ff;
   localparam logic [11:0] OFS_SERDES_PLL    = 12'h56e;
   localparam logic [11:0] OFS_MULTIFRAME_CLOCK_OFFSET   = 12'h578;
   localparam logic [11:0] OFS_SUBCLASS      = 12'h590;
   localparam logic [11:0] OFS_LINK_PARAM    = 12'h5a0;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int SYSREF_TRANS_BIT = 4;
   localparam int SYSREF_EDGE_BIT  = 3;
   localparam int SYSREF_MODE_LSB  = 1;
   localparam int SUBCLASS_LSB     = 5;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_SYSREF_CTRL = 8'h00;
   localparam logic [7:0] RST_CHIP_SYNC   = 8'h00;
   localparam logic [7:0] RST_SERDES_PLL  = 8'h00;
   localparam logic [7:0] RST_MULTIFRAME_CLOCK_OFFSET = 8'h00;
   localparam logic [7:0] RST_SUBCLASS    = 8'h20;
   // Link params: F-1 in [3:0], K-1 in [12:8]: F=4, K=32, S=1
   localparam logic [7:0] RST_F_MINUS1    = 8'h03;
   localparam logic [7:0] RST_K_MINUS1    = 8'h1f;

   // ------------------------------------------------------------
   // Fixed example configuration
   // ------------------------------------------------------------
   localparam int CHIP_DECIMATION_RATIO = 8;
   localparam int SAMPLE_WORD_BITS      = 16;
   localparam int SAMPLE_RES_BITS       = 14;
   localparam int VIRT_CONVERTERS       = 4;
   localparam int FRAMES_PER_MF         = 32;

   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_CONT   = 2'h1;
   localparam logic [1:0] MODE_NSHOT  = 2'h2;

   typedef struct packed {
      logic [11:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } bus_req_s;

   typedef struct packed {
      logic        lmfc_tick;
      logic        frame_tick;
      logic        div_reset;
      logic [2:0]  div_phase;
   } lmfc_out_s;

endpackage

// ### hw/sysref_capture.sv
`timescale 1ns/100ps
`default_nettype none
module sysref_capture
   import lmfc_align_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sysref_rise,
   input  wire logic       sysref_fall,
   input  wire logic       trans_sel,
   input  wire logic       edge_sel,
   output logic            event_pulse,
   output logic [7:0]      monitor
);
   logic       hist_reg;
   logic       hist_next;
   logic [7:0] mon_reg;
   logic [7:0] mon_next;
   logic       smp;
   logic       ev;

   // ------------------------------------------------------------
   // Sample and detect transition
   // ------------------------------------------------------------
   always_comb begin
      smp       = edge_sel ? sysref_fall : sysref_rise;
      hist_next = smp;
      ev        = trans_sel ? (hist_reg & ~smp) : (~hist_reg & smp);
      mon_next  = mon_reg;
      if (ev) begin
         // Low nibble: disagreement between the two edges; high: count
         mon_next[3:0] = {3'h0, sysref_rise ^ sysref_fall};
         mon_next[7:4] = mon_reg[7:4] + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hist_reg <= 1'b0;
         mon_reg  <= 8'h00;
      end else begin
         hist_reg <= hist_next;
         mon_reg  <= mon_next;
      end
   end

   assign event_pulse = ev;
   assign monitor     = mon_reg;
endmodule // sysref_capture
`default_nettype wire

// ### verification/lmfc_align_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module lmfc_align_chk (
   input  wire logic                      CLK_SYS,
   input  wire logic                      RST,
   input  wire logic                      AVS_READ,
   input  wire logic                      AVS_WRITE,
   input  wire logic                      AVS_WAITREQUEST,
   input  wire lmfc_align_pkg::lmfc_out_s LMFC_OUT,
   input  wire logic                      SUBCLASS1_ACTIVE,
   input  wire logic                      TIMESTAMP_MODE
);
   import lmfc_align_pkg::*;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=>
      !AVS_WAITREQUEST) else $error("bus request not answered");
   a_ack_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("ack longer than one cycle");
   a_realign_gate: assert property (LMFC_OUT.div_reset |->
      $past(SUBCLASS1_ACTIVE) && !$past(TIMESTAMP_MODE)) else $error("realign not allowed");
   a_realign_phase: assert property (LMFC_OUT.div_reset |->
      LMFC_OUT.div_phase == 3'h0 ##1 LMFC_OUT.div_phase == 3'h1) else $error("divider not reset");
   a_phase_count: assert property (!$past(RST) && !LMFC_OUT.div_reset |->
      LMFC_OUT.div_phase == 3'($past(LMFC_OUT.div_phase) + 3'h1)) else $error("divider stalls");
   a_lmfc_frame: assert property (LMFC_OUT.lmfc_tick |-> LMFC_OUT.frame_tick)
      else $error("multiframe tick off frame boundary");
   a_frame_gap: assert property (LMFC_OUT.frame_tick |=> !LMFC_OUT.frame_tick)
      else $error("frame shorter than two octets");
   a_tick_single: assert property (LMFC_OUT.lmfc_tick |=> !LMFC_OUT.lmfc_tick [*8])
      else $error("multiframe ticks too close");
endmodule // lmfc_align_chk
bind lmfc_sysref_latency_align lmfc_align_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .LMFC_OUT(LMFC_OUT), .SUBCLASS1_ACTIVE(SUBCLASS1_ACTIVE), .TIMESTAMP_MODE(TIMESTAMP_MODE));
`default_nettype wire

// ### verification/sysref_source.sv
`timescale 1ns/100ps
`default_nettype none
module sysref_source #(
   parameter int PULSE_W = 3
) (
   input  wire logic clk,
   input  wire logic fire,
   output logic      sysref_rise,
   output logic      sysref_fall
);
   logic [7:0] cnt_reg  = 8'h00;
   logic       late_reg = 1'b0;
   // One pulse per command only, so no periodic drift against the multiframe
   always_ff @(posedge clk) begin
      if (fire) begin
         cnt_reg <= 8'(PULSE_W);
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
      late_reg <= sysref_rise;
   end
   // Falling-edge sample is seen one cycle after the rising-edge sample
   assign sysref_rise = (cnt_reg != 8'h00);
   assign sysref_fall = late_reg;
endmodule // sysref_source
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import lmfc_align_pkg::*;
   localparam int W = 3;
   typedef struct packed { logic [11:0] a; logic [7:0] d; logic [7:0] e; } row_s;
   logic        CLK_SYS = 1'b0;
   logic        RST = 1'b1;
   logic [11:0] AVS_ADDRESS = 12'h000;
   logic        AVS_READ = 1'b0;
   logic        AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic        fire = 1'b0;
   logic [31:0] AVS_READDATA, q, m0;
   logic        AVS_WAITREQUEST, SYSREF_RISE, SYSREF_FALL, SUBCLASS1_ACTIVE, TIMESTAMP_MODE;
   lmfc_out_s   LMFC_OUT;
   int          n_fail = 0;
   int          cmp_count = 0;
   int          lat, dly, per, l0, d0, ex;
   logic [11:0] ra [5] = '{12'h120, 12'h1ff, 12'h56e, 12'h578, 12'h590};
   logic [7:0]  rv [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
   row_s rows [13] = '{'{12'h120, 8'h1e, 8'h1e}, '{12'h120, 8'h00, 8'h00},
      '{12'h1ff, 8'h01, 8'h01}, '{12'h1ff, 8'h00, 8'h00}, '{12'h56e, 8'h30, 8'h30},
      '{12'h56e, 8'h10, 8'h10}, '{12'h56e, 8'h00, 8'h00}, '{12'h578, 8'h1f, 8'h1f},
      '{12'h578, 8'h00, 8'h00}, '{12'h590, 8'h00, 8'h00}, '{12'h590, 8'h20, 8'h20},
      '{12'h004, 8'h5a, 8'h00}, '{12'h128, 8'h00, 8'h00}};

   lmfc_sysref_latency_align dut (.CLK_SYS(CLK_SYS), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .SYSREF_RISE(SYSREF_RISE), .SYSREF_FALL(SYSREF_FALL), .LMFC_OUT(LMFC_OUT),
      .SUBCLASS1_ACTIVE(SUBCLASS1_ACTIVE), .TIMESTAMP_MODE(TIMESTAMP_MODE));
   sysref_source #(.PULSE_W(W)) u_src (.clk(CLK_SYS), .fire(fire),
      .sysref_rise(SYSREF_RISE), .sysref_fall(SYSREF_FALL));

   initial begin
      forever #5 CLK_SYS = ~CLK_SYS;
   end

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic bus(input logic [11:0] a, input logic w, input logic [15:0] d);
      int k;
      k = 0;
      @(posedge CLK_SYS);
      AVS_ADDRESS <= a;
      AVS_READ <= !w;
      AVS_WRITE <= w;
      AVS_WRITEDATA <= {16'h0, d};
      @(posedge CLK_SYS);
      while (AVS_WAITREQUEST !== 1'b0 && k < 40) begin
         @(posedge CLK_SYS);
         k++;
      end
      if (k == 40) chk("bus answer", 32'h0, 32'h1);
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask

   task automatic sync(input logic [7:0] ctrl);
      bus(12'h120, 1'b1, {8'h00, ctrl});
      @(posedge CLK_SYS) fire <= 1'b1;
      @(posedge CLK_SYS) fire <= 1'b0;
      lat = 0;
      dly = 0;
      per = 0;
      while (LMFC_OUT.div_reset !== 1'b1 && lat < 60) begin
         @(posedge CLK_SYS);
         lat++;
      end
      if (lat < 60) begin
         chk("div phase", 32'(LMFC_OUT.div_phase), 32'h0);
         do begin
            @(posedge CLK_SYS);
            dly++;
         end while (LMFC_OUT.lmfc_tick !== 1'b1 && dly < 300);
         do begin
            @(posedge CLK_SYS);
            per++;
         end while (LMFC_OUT.lmfc_tick !== 1'b1 && per < 300);
      end
   endtask

   task automatic do_reset();
      RST <= 1'b1;
      repeat (6) @(posedge CLK_SYS);
      RST <= 1'b0;
      chk("subclass1 active", 32'(SUBCLASS1_ACTIVE), 32'h1);
      chk("timestamp mode", 32'(TIMESTAMP_MODE), 32'h0);
      for (int i = 0; i < 5; i++) begin
         bus(ra[i], 1'b0, 16'h0000);
         chk("reset value", q, {24'h0, rv[i]});
      end
   endtask

   task automatic final_report();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #500000;
      n_fail++;
      final_report();
   end

   initial begin
      do_reset();
      foreach (rows[i]) begin
         bus(rows[i].a, 1'b1, {8'h00, rows[i].d});
         bus(rows[i].a, 1'b0, 16'h0000);
         if (rows[i].a != 12'h128) begin
            chk("reg readback", q, {24'h0, rows[i].e});
         end
      end
      for (int i = 0; i < 4; i++) begin
         sync(8'h02 | 8'(i << 3));
         if (i == 0) begin
            l0 = lat;
            d0 = dly;
            chk("sysref to realign", 32'(lat), 32'd2);
            chk("first multiframe", 32'(dly), 32'd4);
            chk("multiframe period", 32'(per), 32'd128);
         end
         ex = l0 + (i[1] ? W : 0) + (i[0] ? 1 : 0);
         chk("sysref latency", 32'(lat), 32'(ex));
      end
      bus(12'h578, 1'b1, 16'h0003);
      sync(8'h02);
      chk("offset delay", 32'(dly), 32'(d0 + 12));
      sync(8'h04);
      chk("nshot realign", 32'(lat < 60), 32'h1);
      bus(12'h120, 1'b0, 16'h0000);
      chk("nshot clear", q, 32'h0);
      bus(12'h128, 1'b0, 16'h0000);
      m0 = q;
      chk("monitor events", m0, 32'h61);
      bus(12'h128, 1'b1, 16'h00ff);
      bus(12'h128, 1'b0, 16'h0000);
      chk("monitor read only", q, m0);
      bus(12'h5a0, 1'b1, 16'h1f01);
      sync(8'h02);
      chk("two octet offset", 32'(dly), 32'd6);
      chk("two octet period", 32'(per), 32'd64);
      sync(8'h00);
      chk("mode off", 32'(lat < 60), 32'h0);
      bus(12'h1ff, 1'b1, 16'h0001);
      @(posedge CLK_SYS);
      chk("timestamp mode", 32'(TIMESTAMP_MODE), 32'h1);
      sync(8'h02);
      chk("timestamp no realign", 32'(lat < 60), 32'h0);
      bus(12'h1ff, 1'b1, 16'h0000);
      bus(12'h590, 1'b1, 16'h0000);
      @(posedge CLK_SYS);
      chk("subclass0", 32'(SUBCLASS1_ACTIVE), 32'h0);
      sync(8'h02);
      chk("subclass0 no realign", 32'(lat < 60), 32'h0);
      bus(12'h1ff, 1'b1, 16'h0001);
      do_reset();
      final_report();
   end
endmodule // tb
`default_nettype wire
